// ==== inc/oakgb_defs.vh ====
// Register map, field positions, codes and reset values of the compositor
`ifndef OAKGB_DEFS_VH
`define OAKGB_DEFS_VH

`define OAKGB_IDX_BLEND 12'h836
`define OAKGB_IDX_KEYR 12'h838
`define OAKGB_IDX_KEYG 12'h83a
`define OAKGB_IDX_KEYB 12'h83c
`define OAKGB_IDX_GAMMA 12'h83e
`define OAKGB_IDX_STATUS 12'h846
`define OAKGB_IDX_KEYCNT 12'h848

`define OAKGB_RST_BLEND 16'h0000
`define OAKGB_RST_KEY 16'h0000
`define OAKGB_RST_GAMMA 16'h0000

`define OAKGB_MASK_BLEND 16'h77ff
`define OAKGB_MASK_KEY 16'h00ff
`define OAKGB_MASK_GAMMA 16'h7f3f

`define OAKGB_BM_SHIFT 14
`define OAKGB_BM_SWAP 13
`define OAKGB_BM_TRANS 12
`define OAKGB_BM_MODE_HI 10
`define OAKGB_BM_MODE_LO 9
`define OAKGB_BM_ENABLE 8
`define OAKGB_BM_CONST_HI 7

`define OAKGB_GC_MAIN_BYP 14
`define OAKGB_GC_SEC_BYP 13
`define OAKGB_GC_FIRST_BYP 12
`define OAKGB_GC_WSEL_HI 11
`define OAKGB_GC_WSEL_LO 10
`define OAKGB_GC_BANK_HI 5
`define OAKGB_GC_BANK_LO 4
`define OAKGB_GC_LUT_EN 0

`define OAKGB_MODE_CONST 2'b00
`define OAKGB_MODE_MAP 2'b01
`define OAKGB_MODE_BOTH 2'b10

`define OAKGB_BANK_VP_A 2'b00
`define OAKGB_BANK_VP_B 2'b01
`define OAKGB_BANK_SPLIT 2'b10
`define OAKGB_BANK_HOST 2'b11

`define OAKGB_WSEL_BOTH 2'b00
`define OAKGB_WSEL_FIRST 2'b01
`define OAKGB_WSEL_SECOND 2'b10

`define OAKGB_WIN_MAIN 2'b00
`define OAKGB_WIN_FIRST 2'b01
`define OAKGB_WIN_SECOND 2'b10

`define OAKGB_AFMT_1BIT 2'b00
`define OAKGB_AFMT_4BIT 2'b01
`define OAKGB_AFMT_8BIT 2'b10

`define OAKGB_ALPHA_HALF 8'h80

`endif

// ==== rtl/oakgb_alpha.v ====
// Effective alpha selection from constant and per-pixel map alpha
`timescale 1ns/1ps
`include "oakgb_defs.vh"
module oakgb_alpha (
    input wire [1:0] mode,
    input wire shiftEn,
    input wire [7:0] constAlpha,
    input wire [7:0] mapRaw,
    input wire [1:0] mapFmt,
    output reg [7:0] alphaOut
);
    reg [7:0] mapConv;
    reg [7:0] mapFinal;
    reg [15:0] prod;

    always @* begin
        // Expand map alpha to an 8-bit fraction of 256
        case (mapFmt)
            `OAKGB_AFMT_1BIT: mapConv = mapRaw[0] ? `OAKGB_ALPHA_HALF : 8'h00;
            `OAKGB_AFMT_4BIT: mapConv = {mapRaw[3:0], 4'h0};
            default: mapConv = mapRaw;
        endcase
        if (shiftEn && (mode != `OAKGB_MODE_CONST) && (mapConv != 8'h00)) begin
            mapFinal = {mapConv[7], mapConv[7:1]};
        end else begin
            mapFinal = mapConv;
        end
        prod = {8'h00, mapFinal} * {8'h00, constAlpha};
        case (mode)
            `OAKGB_MODE_MAP: alphaOut = mapFinal;
            `OAKGB_MODE_BOTH: alphaOut = prod[15:8];
            // Reserved mode falls back to constant alpha
            default: alphaOut = constAlpha;
        endcase
    end
endmodule // oakgb_alpha

// ==== rtl/oakgb_blend_ch.v ====
// One colour component of the alpha blend
`timescale 1ns/1ps
module oakgb_blend_ch (
    input wire [7:0] ovlVal,
    input wire [7:0] mainVal,
    input wire [7:0] alpha,
    input wire swap,
    output wire [7:0] result
);
    wire [7:0] fgVal;
    wire [7:0] bgVal;
    wire [8:0] invAlpha;
    wire [16:0] prodFg;
    wire [16:0] prodBg;
    wire [16:0] sum;

    assign fgVal = swap ? mainVal : ovlVal;
    assign bgVal = swap ? ovlVal : mainVal;
    assign invAlpha = 9'h100 - {1'b0, alpha};
    assign prodFg = {9'h000, fgVal} * {9'h000, alpha};
    assign prodBg = {9'h000, bgVal} * {8'h00, invAlpha};
    // Peak sum is 255 * 256, so bits 15:8 never overflow
    assign sum = prodFg + prodBg;
    assign result = sum[15:8];
endmodule // oakgb_blend_ch

// ==== rtl/oakgb_top.v ====
// Overlay compositor with colour key, gamma routing and register slave
`timescale 1ns/1ps
`include "oakgb_defs.vh"
module oakgb_top #(
    parameter ADDR_W = 14,
    parameter CNT_W = 16
) (
    input wire clk,
    input wire rstn,
    input wire [ADDR_W-1:0] avsAddress,
    input wire avsRead,
    input wire avsWrite,
    input wire [31:0] avsWriteData,
    input wire [3:0] avsByteEnable,
    output wire [31:0] avsReadData,
    output wire avsWaitRequest,
    input wire pixValid,
    input wire [7:0] pixMainR,
    input wire [7:0] pixMainG,
    input wire [7:0] pixMainB,
    input wire pixMainIsFirst,
    input wire pixOvlHit,
    input wire [7:0] pixOvlR,
    input wire [7:0] pixOvlG,
    input wire [7:0] pixOvlB,
    input wire [7:0] pixOvlAlpha,
    input wire [1:0] pixAlphaFmt,
    input wire ovlArgbEn,
    output wire outValid,
    output wire [7:0] outR,
    output wire [7:0] outG,
    output wire [7:0] outB,
    output wire [1:0] outWin,
    output wire outGammaOn,
    output wire outGammaBankB,
    output wire lutHostAccA,
    output wire lutHostAccB
);
    reg rstSync1_r;
    reg rstSync2_r;
    wire rstnInt;

    reg [15:0] blendReg_r;
    reg [15:0] keyRed_r;
    reg [15:0] keyGreen_r;
    reg [15:0] keyBlue_r;
    reg [15:0] gammaReg_r;
    reg [CNT_W-1:0] keyCnt_r;
    reg [CNT_W-1:0] keyCnt_nxt;

    reg waitReq_r;
    reg [31:0] readData_r;
    reg [15:0] readMux;
    wire [11:0] regIdx;
    wire busReq;
    wire busDone;
    wire wrDone;

    // Stage one holds the pixel with its resolved alpha and key decision
    reg s1Valid_r;
    reg [7:0] s1MainR_r;
    reg [7:0] s1MainG_r;
    reg [7:0] s1MainB_r;
    reg [7:0] s1OvlR_r;
    reg [7:0] s1OvlG_r;
    reg [7:0] s1OvlB_r;
    reg s1MainFirst_r;
    reg s1Show_r;
    reg s1Blend_r;
    reg s1Keyed_r;
    reg s1Swap_r;
    reg [7:0] s1Alpha_r;

    reg outValid_r;
    reg [7:0] outR_r;
    reg [7:0] outG_r;
    reg [7:0] outB_r;
    reg [1:0] outWin_r;
    reg outGammaOn_r;
    reg outGammaBankB_r;
    reg lastKeyed_r;
    reg lastBlend_r;
    reg lutHostAccA_r;
    reg lutHostAccB_r;

    wire [1:0] blendMode;
    wire [7:0] alphaEff;
    wire keyMatch;
    wire ovlShown;
    wire [7:0] blendR;
    wire [7:0] blendG;
    wire [7:0] blendB;
    wire [1:0] s1Win;
    wire [1:0] bankSel;
    wire [1:0] winSel;
    wire lutEn;
    reg gammaOn;
    reg gammaBankB;
    reg winBypass;
    reg hostA;
    reg hostB;

    // Reset is released through two flops; assertion stays asynchronous
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rstSync1_r <= 1'b0;
            rstSync2_r <= 1'b0;
        end else begin
            rstSync1_r <= 1'b1;
            rstSync2_r <= rstSync1_r;
        end
    end
    assign rstnInt = rstSync2_r;

    // Register slave: one wait cycle, then waitrequest low with read data
    assign regIdx = avsAddress[13:2];
    assign busReq = avsRead | avsWrite;
    assign busDone = busReq & ~waitReq_r;
    assign wrDone = avsWrite & ~waitReq_r;

    function [15:0] mergeBytes;
        input [15:0] oldVal;
        input [31:0] wdata;
        input [3:0] be;
        input [15:0] mask;
        begin
            mergeBytes[15:8] = be[1] ? wdata[15:8] : oldVal[15:8];
            mergeBytes[7:0] = be[0] ? wdata[7:0] : oldVal[7:0];
            mergeBytes = mergeBytes & mask;
        end
    endfunction

    always @* begin
        case (regIdx)
            `OAKGB_IDX_BLEND: readMux = blendReg_r;
            `OAKGB_IDX_KEYR: readMux = keyRed_r;
            `OAKGB_IDX_KEYG: readMux = keyGreen_r;
            `OAKGB_IDX_KEYB: readMux = keyBlue_r;
            `OAKGB_IDX_GAMMA: readMux = gammaReg_r;
            `OAKGB_IDX_STATUS: readMux = {11'h000, lutHostAccB_r,
                lutHostAccA_r, outGammaOn_r, lastBlend_r, lastKeyed_r};
            `OAKGB_IDX_KEYCNT: readMux = keyCnt_r[15:0];
            default: readMux = 16'h0000;
        endcase
    end

    always @(posedge clk or negedge rstnInt) begin
        if (!rstnInt) begin
            waitReq_r <= 1'b1;
            readData_r <= 32'h00000000;
        end else begin
            if (busReq && waitReq_r) begin
                waitReq_r <= 1'b0;
                readData_r <= avsRead ? {16'h0000, readMux} : 32'h00000000;
            end else begin
                waitReq_r <= 1'b1;
            end
        end
    end

    always @(posedge clk or negedge rstnInt) begin
        if (!rstnInt) begin
            blendReg_r <= `OAKGB_RST_BLEND;
            keyRed_r <= `OAKGB_RST_KEY;
            keyGreen_r <= `OAKGB_RST_KEY;
            keyBlue_r <= `OAKGB_RST_KEY;
            gammaReg_r <= `OAKGB_RST_GAMMA;
        end else if (wrDone) begin
            case (regIdx)
                `OAKGB_IDX_BLEND: blendReg_r <= mergeBytes(blendReg_r,
                    avsWriteData, avsByteEnable, `OAKGB_MASK_BLEND);
                `OAKGB_IDX_KEYR: keyRed_r <= mergeBytes(keyRed_r,
                    avsWriteData, avsByteEnable, `OAKGB_MASK_KEY);
                `OAKGB_IDX_KEYG: keyGreen_r <= mergeBytes(keyGreen_r,
                    avsWriteData, avsByteEnable, `OAKGB_MASK_KEY);
                `OAKGB_IDX_KEYB: keyBlue_r <= mergeBytes(keyBlue_r,
                    avsWriteData, avsByteEnable, `OAKGB_MASK_KEY);
                `OAKGB_IDX_GAMMA: gammaReg_r <= mergeBytes(gammaReg_r,
                    avsWriteData, avsByteEnable, `OAKGB_MASK_GAMMA);
                default: begin
                end
            endcase
        end
    end

    // Keyed pixel counter; a write clears it but a same-cycle hit still counts
    always @* begin
        keyCnt_nxt = keyCnt_r;
        if (wrDone && (regIdx == `OAKGB_IDX_KEYCNT)) begin
            keyCnt_nxt = {CNT_W{1'b0}};
        end
        if (s1Valid_r && s1Keyed_r && (keyCnt_nxt != {CNT_W{1'b1}})) begin
            keyCnt_nxt = keyCnt_nxt + {{(CNT_W-1){1'b0}}, 1'b1};
        end
    end

    always @(posedge clk or negedge rstnInt) begin
        if (!rstnInt) begin
            keyCnt_r <= {CNT_W{1'b0}};
        end else begin
            keyCnt_r <= keyCnt_nxt;
        end
    end

    // Alpha resolution; map modes expect the alpha-carrying format enabled
    assign blendMode = blendReg_r[`OAKGB_BM_MODE_HI:`OAKGB_BM_MODE_LO];

    oakgb_alpha u_alpha (
        .mode(blendMode),
        .shiftEn(blendReg_r[`OAKGB_BM_SHIFT]),
        .constAlpha(blendReg_r[`OAKGB_BM_CONST_HI:0]),
        .mapRaw(ovlArgbEn ? pixOvlAlpha : 8'h00),
        .mapFmt(pixAlphaFmt),
        .alphaOut(alphaEff)
    );

    // Key compares all three components against the key colour
    assign keyMatch = blendReg_r[`OAKGB_BM_TRANS] &&
        (pixOvlR == keyRed_r[7:0]) &&
        (pixOvlG == keyGreen_r[7:0]) &&
        (pixOvlB == keyBlue_r[7:0]);
    assign ovlShown = pixOvlHit & ~keyMatch;

    always @(posedge clk or negedge rstnInt) begin
        if (!rstnInt) begin
            s1Valid_r <= 1'b0;
            s1MainR_r <= 8'h00;
            s1MainG_r <= 8'h00;
            s1MainB_r <= 8'h00;
            s1OvlR_r <= 8'h00;
            s1OvlG_r <= 8'h00;
            s1OvlB_r <= 8'h00;
            s1MainFirst_r <= 1'b0;
            s1Show_r <= 1'b0;
            s1Blend_r <= 1'b0;
            s1Keyed_r <= 1'b0;
            s1Swap_r <= 1'b0;
            s1Alpha_r <= 8'h00;
        end else begin
            s1Valid_r <= pixValid;
            if (pixValid) begin
                s1MainR_r <= pixMainR;
                s1MainG_r <= pixMainG;
                s1MainB_r <= pixMainB;
                s1OvlR_r <= pixOvlR;
                s1OvlG_r <= pixOvlG;
                s1OvlB_r <= pixOvlB;
                s1MainFirst_r <= pixMainIsFirst;
                s1Show_r <= ovlShown;
                s1Blend_r <= blendReg_r[`OAKGB_BM_ENABLE];
                s1Keyed_r <= pixOvlHit & keyMatch;
                s1Swap_r <= blendReg_r[`OAKGB_BM_SWAP];
                s1Alpha_r <= alphaEff;
            end
        end
    end

    oakgb_blend_ch u_blend_r (
        .ovlVal(s1OvlR_r),
        .mainVal(s1MainR_r),
        .alpha(s1Alpha_r),
        .swap(s1Swap_r),
        .result(blendR)
    );

    oakgb_blend_ch u_blend_g (
        .ovlVal(s1OvlG_r),
        .mainVal(s1MainG_r),
        .alpha(s1Alpha_r),
        .swap(s1Swap_r),
        .result(blendG)
    );

    oakgb_blend_ch u_blend_b (
        .ovlVal(s1OvlB_r),
        .mainVal(s1MainB_r),
        .alpha(s1Alpha_r),
        .swap(s1Swap_r),
        .result(blendB)
    );

    // Gamma routing per window from bank and window select
    assign s1Win = s1Show_r ? `OAKGB_WIN_SECOND :
        (s1MainFirst_r ? `OAKGB_WIN_FIRST : `OAKGB_WIN_MAIN);
    assign bankSel = gammaReg_r[`OAKGB_GC_BANK_HI:`OAKGB_GC_BANK_LO];
    assign winSel = gammaReg_r[`OAKGB_GC_WSEL_HI:`OAKGB_GC_WSEL_LO];
    assign lutEn = gammaReg_r[`OAKGB_GC_LUT_EN];

    always @* begin
        case (s1Win)
            `OAKGB_WIN_FIRST: winBypass = gammaReg_r[`OAKGB_GC_FIRST_BYP];
            `OAKGB_WIN_SECOND: winBypass = gammaReg_r[`OAKGB_GC_SEC_BYP];
            default: winBypass = gammaReg_r[`OAKGB_GC_MAIN_BYP];
        endcase
        gammaOn = 1'b0;
        gammaBankB = 1'b0;
        hostA = 1'b0;
        hostB = 1'b0;
        case (bankSel)
            `OAKGB_BANK_VP_A: begin
                gammaOn = (s1Win != `OAKGB_WIN_SECOND);
                hostB = 1'b1;
            end
            `OAKGB_BANK_VP_B: begin
                gammaOn = (s1Win != `OAKGB_WIN_SECOND);
                gammaBankB = 1'b1;
                hostA = 1'b1;
            end
            `OAKGB_BANK_SPLIT: begin
                case (s1Win)
                    `OAKGB_WIN_FIRST: gammaOn = (winSel == `OAKGB_WSEL_BOTH) ||
                        (winSel == `OAKGB_WSEL_FIRST);
                    `OAKGB_WIN_SECOND: gammaOn = (winSel == `OAKGB_WSEL_BOTH) ||
                        (winSel == `OAKGB_WSEL_SECOND);
                    default: gammaOn = 1'b1;
                endcase
                gammaBankB = (s1Win != `OAKGB_WIN_MAIN);
            end
            default: begin
                hostA = 1'b1;
                hostB = 1'b1;
            end
        endcase
        // Unselected windows are already off; the per-window bypass bits and the LUT enable gate the rest
        gammaOn = gammaOn & ~winBypass & lutEn;
        hostA = hostA & lutEn;
        hostB = hostB & lutEn;
    end

    always @(posedge clk or negedge rstnInt) begin
        if (!rstnInt) begin
            outValid_r <= 1'b0;
            outR_r <= 8'h00;
            outG_r <= 8'h00;
            outB_r <= 8'h00;
            outWin_r <= `OAKGB_WIN_MAIN;
            outGammaOn_r <= 1'b0;
            outGammaBankB_r <= 1'b0;
            lastKeyed_r <= 1'b0;
            lastBlend_r <= 1'b0;
            lutHostAccA_r <= 1'b0;
            lutHostAccB_r <= 1'b0;
        end else begin
            outValid_r <= s1Valid_r;
            lutHostAccA_r <= hostA;
            lutHostAccB_r <= hostB;
            if (s1Valid_r) begin
                if (!s1Show_r) begin
                    outR_r <= s1MainR_r;
                    outG_r <= s1MainG_r;
                    outB_r <= s1MainB_r;
                end else if (s1Blend_r) begin
                    outR_r <= blendR;
                    outG_r <= blendG;
                    outB_r <= blendB;
                end else begin
                    outR_r <= s1OvlR_r;
                    outG_r <= s1OvlG_r;
                    outB_r <= s1OvlB_r;
                end
                outWin_r <= s1Win;
                outGammaOn_r <= gammaOn;
                outGammaBankB_r <= gammaBankB;
                lastKeyed_r <= s1Keyed_r;
                lastBlend_r <= s1Show_r & s1Blend_r;
            end
        end
    end

    assign avsReadData = readData_r;
    assign avsWaitRequest = waitReq_r;
    assign outValid = outValid_r;
    assign outR = outR_r;
    assign outG = outG_r;
    assign outB = outB_r;
    assign outWin = outWin_r;
    assign outGammaOn = outGammaOn_r;
    assign outGammaBankB = outGammaBankB_r;
    assign lutHostAccA = lutHostAccA_r;
    assign lutHostAccB = lutHostAccB_r;
endmodule // oakgb_top

// ==== testbench/oakgb_top_asserts.sv ====
// Port-level checker for the overlay compositor
`timescale 1ns/1ps
module oakgb_top_asserts (
    input wire clk,
    input wire rstn,
    input wire avsRead,
    input wire avsWrite,
    input wire [31:0] avsReadData,
    input wire avsWaitRequest,
    input wire pixValid,
    input wire [7:0] pixMainR,
    input wire pixMainIsFirst,
    input wire pixOvlHit,
    input wire [7:0] pixOvlR,
    input wire outValid,
    input wire [7:0] outR,
    input wire [1:0] outWin,
    input wire outGammaOn,
    input wire outGammaBankB,
    input wire lutHostAccA,
    input wire lutHostAccB
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    sequence sBehind;
        pixValid && !pixOvlHit;
    endsequence
    sequence sSame;
        pixValid && pixOvlR == pixMainR;
    endsequence
    sequence sResult;
        ##2 outValid;
    endsequence
    AST_OUT_LAT: assert property (pixValid |-> sResult)
        else $error("pixel result not two cycles after input");
    AST_NO_SPUR: assert property (outValid |-> $past(pixValid, 2))
        else $error("result without an input pixel");
    AST_BEHIND: assert property (sBehind |-> sResult ##0
        (outR == $past(pixMainR, 2) && outWin == {1'b0, $past(pixMainIsFirst, 2)}))
        else $error("pixel outside overlay not passed through");
    AST_SAME: assert property (sSame |-> ##2 outR == $past(pixMainR, 2))
        else $error("blend of equal colours changed the colour");
    AST_HOLD: assert property (!outValid |-> $stable(outR))
        else $error("result changed between valids");
    AST_WIN_OK: assert property (outValid |-> outWin != 2'b11)
        else $error("window code out of range");
    AST_WAIT_ANS: assert property ((avsRead || avsWrite) |-> ##[0:1] !avsWaitRequest)
        else $error("bus answer late");
    AST_WAIT_PULSE: assert property (!avsWaitRequest |=> avsWaitRequest)
        else $error("waitrequest low for more than one cycle");
    AST_RD_UPPER: assert property (avsRead && !avsWaitRequest |-> avsReadData[31:16] == 16'h0000)
        else $error("read data upper half not zero");
    AST_HOST_EXCL: assert property (outValid && outGammaOn |->
        !(outGammaBankB ? lutHostAccB : lutHostAccA))
        else $error("bank used for correction while open to host");
endmodule // oakgb_top_asserts

bind oakgb_top oakgb_top_asserts u_chk (
    .clk(clk), .rstn(rstn), .avsRead(avsRead), .avsWrite(avsWrite),
    .avsReadData(avsReadData), .avsWaitRequest(avsWaitRequest),
    .pixValid(pixValid), .pixMainR(pixMainR),
    .pixMainIsFirst(pixMainIsFirst), .pixOvlHit(pixOvlHit),
    .pixOvlR(pixOvlR), .outValid(outValid), .outR(outR), .outWin(outWin),
    .outGammaOn(outGammaOn), .outGammaBankB(outGammaBankB),
    .lutHostAccA(lutHostAccA), .lutHostAccB(lutHostAccB)
);

// ==== testbench/oakgb_pix_src.sv ====
// Pixel source standing in for the display buffer fetch path
`timescale 1ns/1ps
module oakgb_pix_src (
    input wire clk,
    input wire send,
    input wire [7:0] mainIn,
    input wire [7:0] ovlIn,
    input wire [7:0] alphaIn,
    input wire [3:0] flagIn,
    output reg pixValid = 1'b0,
    output reg [7:0] mainOut = 8'h00,
    output reg [7:0] ovlOut = 8'h00,
    output reg [7:0] alphaOut = 8'h00,
    output reg [3:0] flagOut = 4'h0
);
    // Between pixels pixValid stays low and the data and flag lines invert on every clock, starting from the last pixel
    always @(posedge clk) begin
        pixValid <= send;
        if (send) begin
            mainOut <= mainIn;
            ovlOut <= ovlIn;
            alphaOut <= alphaIn;
            flagOut <= flagIn;
        end else begin
            mainOut <= ~mainOut;
            ovlOut <= ~ovlOut;
            alphaOut <= ~alphaOut;
            flagOut <= ~flagOut;
        end
    end
endmodule // oakgb_pix_src

// ==== testbench/oakgb_top_tb.sv ====
// Self-checking bench of the overlay compositor
`timescale 1ns/1ps
`include "oakgb_defs.vh"
module oakgb_top_tb;
    typedef struct packed {
        logic [15:0] bl;
        logic [15:0] gm;
        logic [7:0] m;
        logic [7:0] o;
        logic [7:0] a;
        logic [4:0] fl;
        logic [7:0] res;
        logic [3:0] eg;
    } oakgb_row_t;
    // fl = {argb, hit, first, fmt}; eg = {window, gamma on, bank B}
    oakgb_row_t rw [20] = '{
        '{16'h0140,16'h0000,8'h00,8'hff,8'h00,5'h18,8'h3f,4'h8},
        '{16'h2140,16'h0000,8'h00,8'hff,8'h00,5'h18,8'hbf,4'h8},
        '{16'h0300,16'h0000,8'h00,8'hff,8'h01,5'h18,8'h7f,4'h8},
        '{16'h4300,16'h0000,8'h00,8'hff,8'h01,5'h18,8'hbf,4'h8},
        '{16'h4180,16'h0000,8'h00,8'hff,8'h01,5'h18,8'h7f,4'h8},
        '{16'h4300,16'h0000,8'h20,8'hff,8'h00,5'h18,8'h20,4'h8},
        '{16'h0580,16'h0000,8'h00,8'hff,8'h80,5'h1a,8'h3f,4'h8},
        '{16'h0300,16'h0000,8'h00,8'hff,8'h0f,5'h19,8'hef,4'h8},
        '{16'h0040,16'h0000,8'h00,8'hff,8'h00,5'h18,8'hff,4'h8},
        '{16'h1140,16'h0000,8'h11,8'h5a,8'h00,5'h18,8'h11,4'h0},
        '{16'h0140,16'h0000,8'h11,8'h5a,8'h00,5'h18,8'h23,4'h8},
        '{16'h0740,16'h0000,8'h00,8'hff,8'h00,5'h18,8'h3f,4'h8},
        '{16'h0140,16'h0001,8'h33,8'h00,8'h00,5'h10,8'h33,4'h2},
        '{16'h0140,16'h1001,8'h33,8'h00,8'h00,5'h14,8'h33,4'h4},
        '{16'h0140,16'h4001,8'h33,8'h00,8'h00,5'h10,8'h33,4'h0},
        '{16'h0140,16'h0821,8'h00,8'hff,8'h00,5'h18,8'h3f,4'hb},
        '{16'h0140,16'h2821,8'h00,8'hff,8'h00,5'h18,8'h3f,4'h8},
        '{16'h0140,16'h0421,8'h00,8'hff,8'h00,5'h18,8'h3f,4'h8},
        '{16'h0140,16'h0020,8'h00,8'hff,8'h00,5'h18,8'h3f,4'h8},
        '{16'h0140,16'h0821,8'h33,8'h00,8'h00,5'h10,8'h33,4'h2}
    };
    logic [11:0] ri [5] = '{`OAKGB_IDX_BLEND, `OAKGB_IDX_KEYR,
        `OAKGB_IDX_KEYG, `OAKGB_IDX_KEYB, `OAKGB_IDX_GAMMA};
    logic [15:0] mk [5] = '{16'h77ff, 16'h00ff, 16'h00ff, 16'h00ff, 16'h7f3f};
    logic [15:0] hg [5] = '{16'h0001, 16'h0011, 16'h0031, 16'h0021, 16'h0030};
    logic [1:0] ha [5] = '{2'b01, 2'b10, 2'b11, 2'b00, 2'b00};
    logic [27:0] bq [3] = '{28'h83f3f3f, 28'h0111111, 28'h0333333};
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic [13:0] avsAddress = 14'h0000;
    logic avsRead = 1'b0;
    logic avsWrite = 1'b0;
    logic [31:0] avsWriteData = 32'h00000000;
    logic [3:0] avsByteEnable = 4'h0;
    logic ovlArgbEn = 1'b0;
    logic send = 1'b0;
    logic [7:0] mainIn = 8'h00, ovlIn = 8'h00, alphaIn = 8'h00;
    logic [3:0] flIn = 4'h0;
    wire pixValid, outValid, outGammaOn, outGammaBankB, avsWaitRequest;
    wire lutHostAccA, lutHostAccB;
    wire [7:0] pixMain, pixOvl, pixAlpha, outR, outG, outB;
    wire [3:0] pixFlag;
    wire [1:0] outWin;
    wire [31:0] avsReadData;
    int fail_count = 0;
    int n_tests = 0;
    logic [27:0] got [$];
    logic [27:0] e;
    logic [15:0] q;

    oakgb_pix_src src (.clk(clk), .send(send), .mainIn(mainIn),
        .ovlIn(ovlIn), .alphaIn(alphaIn), .flagIn(flIn),
        .pixValid(pixValid), .mainOut(pixMain), .ovlOut(pixOvl),
        .alphaOut(pixAlpha), .flagOut(pixFlag));
    oakgb_top dut (.clk(clk), .rstn(rstn), .avsAddress(avsAddress),
        .avsRead(avsRead), .avsWrite(avsWrite), .avsWriteData(avsWriteData),
        .avsByteEnable(avsByteEnable), .avsReadData(avsReadData),
        .avsWaitRequest(avsWaitRequest), .pixValid(pixValid),
        .pixMainR(pixMain), .pixMainG(pixMain), .pixMainB(pixMain),
        .pixMainIsFirst(pixFlag[2]), .pixOvlHit(pixFlag[3]),
        .pixOvlR(pixOvl), .pixOvlG(pixOvl), .pixOvlB(pixOvl),
        .pixOvlAlpha(pixAlpha), .pixAlphaFmt(pixFlag[1:0]),
        .ovlArgbEn(ovlArgbEn), .outValid(outValid), .outR(outR),
        .outG(outG), .outB(outB), .outWin(outWin), .outGammaOn(outGammaOn),
        .outGammaBankB(outGammaBankB), .lutHostAccA(lutHostAccA),
        .lutHostAccB(lutHostAccB));

    initial begin
        forever #20 clk = ~clk;
    end
    always @(posedge clk) begin
        if (outValid === 1'b1) begin
            got.push_back({outWin, outGammaOn, outGammaBankB, outR, outG, outB});
        end
    end

    task automatic end_sim;
        if (fail_count == 0 && n_tests > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] x, y);
        n_tests++;
        if (y !== x) begin
            $display("ERROR %s expected %h seen %h", nm, x, y);
            fail_count++;
        end
    endtask
    task automatic bus(input logic wr, input logic [11:0] ix,
        input logic [15:0] d, input logic [3:0] be);
        int n;
        n = 0;
        avsAddress <= {ix, 2'b00};
        avsWriteData <= {16'h0000, d};
        avsByteEnable <= be;
        avsWrite <= wr;
        avsRead <= ~wr;
        do begin
            @(posedge clk);
            n++;
        end while (avsWaitRequest !== 1'b0 && n < 40);
        if (n >= 40) begin
            fail_count++;
            end_sim();
        end
        q = avsReadData[15:0];
        avsWrite <= 1'b0;
        avsRead <= 1'b0;
        @(posedge clk);
    endtask
    task automatic pix(input logic [7:0] m, o, a, input logic [4:0] f);
        ovlArgbEn <= f[4];
        mainIn <= m;
        ovlIn <= o;
        alphaIn <= a;
        flIn <= f[3:0];
        send <= 1'b1;
        @(posedge clk);
    endtask
    task automatic grab(output logic [27:0] r);
        int n;
        n = 0;
        while (got.size() == 0 && n < 20) begin
            @(posedge clk);
            n++;
        end
        if (got.size() == 0) begin
            fail_count++;
            end_sim();
        end
        r = (got.size() == 0) ? 28'h0 : got.pop_front();
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        fail_count++;
        end_sim();
    end
    initial begin
        repeat (5) @(posedge clk);
        rstn <= 1'b1;
        repeat (3) @(posedge clk);
        for (int k = 0; k < 5; k++) begin
            bus(1'b0, ri[k], 16'h0000, 4'h3);
            chk("reset value", 32'h0, {16'h0, q});
            bus(1'b1, ri[k], 16'hffff, 4'h3);
            bus(1'b1, ri[k], 16'h0000, 4'h1);
            bus(1'b0, ri[k], 16'h0000, 4'h3);
            chk("lane mask", {16'h0, mk[k] & 16'hff00}, {16'h0, q});
            bus(1'b1, ri[k], 16'h005a, 4'h3);
        end
        bus(1'b0, 12'h850, 16'h0000, 4'h3);
        chk("unmapped", 32'h0, {16'h0, q});
        for (int i = 0; i < 20; i++) begin
            bus(1'b1, `OAKGB_IDX_BLEND, rw[i].bl, 4'h3);
            bus(1'b1, `OAKGB_IDX_GAMMA, rw[i].gm, 4'h3);
            pix(rw[i].m, rw[i].o, rw[i].a, rw[i].fl);
            send <= 1'b0;
            grab(e);
            if (!rw[i].eg[1]) e[24] = rw[i].eg[0];
            chk("pixel", {rw[i].eg, {3{rw[i].res}}}, e);
        end
        bus(1'b0, `OAKGB_IDX_KEYCNT, 16'h0000, 4'h3);
        chk("keyed count", 32'h1, {16'h0, q});
        for (int k = 0; k < 5; k++) begin
            bus(1'b1, `OAKGB_IDX_GAMMA, hg[k], 4'h3);
            @(posedge clk);
            chk("host access", ha[k], {lutHostAccA, lutHostAccB});
        end
        bus(1'b1, `OAKGB_IDX_BLEND, 16'h1140, 4'h3);
        bus(1'b1, `OAKGB_IDX_GAMMA, 16'h0000, 4'h3);
        pix(8'h00, 8'hff, 8'h00, 5'h18);
        pix(8'h11, 8'h5a, 8'h00, 5'h18);
        pix(8'h33, 8'h00, 8'h00, 5'h10);
        send <= 1'b0;
        for (int k = 0; k < 3; k++) begin
            grab(e);
            e[24] = 1'b0;
            chk("burst", bq[k], e);
        end
        bus(1'b1, `OAKGB_IDX_BLEND, 16'h1234, 4'h3);
        rstn <= 1'b0;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        repeat (3) @(posedge clk);
        bus(1'b0, `OAKGB_IDX_BLEND, 16'h0000, 4'h3);
        chk("second reset", 32'h0, {16'h0, q});
        end_sim();
    end
endmodule // oakgb_top_tb
